// *** shared/alarm_monitor_consts.svh ***
// Offsets, field widths, reset values and timing counts of the alarm monitor
`ifndef ALARM_MONITOR_CONSTS_SVH
`define ALARM_MONITOR_CONSTS_SVH

`define CLK_HZ            20000000
`define TICK_MS           100
`define BATT_DELAY_MS     1000
`define ARM_DELAY_MS      5000
`define BIAS_DELAY_MS     10000

`define NUM_ALARMS        11
`define NUM_SETTINGS      9
`define ADDR_W            6
`define DATA_W            16

`define ADDR_ACTION_BASE  6'h00
`define ADDR_SETTING_BASE 6'h10
`define ADDR_ACTIVE       6'h20
`define ADDR_PENDING      6'h21
`define ADDR_ARMED        6'h22

`define FREQ_TOL          16'h0064

`define ACT_DEF_BATT_HIGH 3'h4
`define ACT_DEF_BATT_LOW  3'h4
`define ACT_DEF_SPD_FREQ  3'h6
`define ACT_DEF_SPD_BIAS  3'h2
`define ACT_DEF_VLT_BIAS  3'h2
`define ACT_DEF_SENSE     3'h4
`define ACT_DEF_ROTATION  3'h6
`define ACT_DEF_OV        3'h6
`define ACT_DEF_OV_PRE    3'h1
`define ACT_DEF_UV_PRE    3'h1
`define ACT_DEF_UV        3'h5

`define SET_DEF_BATT_HIGH 16'h0118
`define SET_DEF_BATT_LOW  16'h00B4
`define SET_DEF_ROTATION  16'h0032
`define SET_DEF_OV        16'h0258
`define SET_DEF_OV_PRE    16'h0226
`define SET_DEF_UV_PRE    16'h0190
`define SET_DEF_UV        16'h012C
`define SET_DEF_AL_DELAY  16'h0064
`define SET_DEF_PRE_DELAY 16'h0032

`endif

// *** shared/alarm_monitor_pkg.sv ***
// Types shared by the alarm monitor and its bench
package alarm_monitor_pkg;

   typedef enum logic [2:0] {
      ACT_DISABLED = 3'h1,
      ACT_WARNING  = 3'h2,
      ACT_LEVEL3   = 3'h3,
      ACT_AUDIBLE  = 3'h4,
      ACT_SOFT     = 3'h5,
      ACT_HARD     = 3'h6
   } action_t;

   typedef enum logic [3:0] {
      AL_BATT_HIGH = 4'h0,
      AL_BATT_LOW  = 4'h1,
      AL_SPD_FREQ  = 4'h2,
      AL_SPD_BIAS  = 4'h3,
      AL_VLT_BIAS  = 4'h4,
      AL_SENSE     = 4'h5,
      AL_ROTATION  = 4'h6,
      AL_OV        = 4'h7,
      AL_OV_PRE    = 4'h8,
      AL_UV_PRE    = 4'h9,
      AL_UV        = 4'hA
   } alarm_id_t;

   typedef enum logic [3:0] {
      SET_BATT_HIGH = 4'h0,
      SET_BATT_LOW  = 4'h1,
      SET_ROTATION  = 4'h2,
      SET_OV        = 4'h3,
      SET_OV_PRE    = 4'h4,
      SET_UV_PRE    = 4'h5,
      SET_UV        = 4'h6,
      SET_AL_DELAY  = 4'h7,
      SET_PRE_DELAY = 4'h8
   } setting_id_t;

endpackage

// *** rtl/genset_alarm_monitor.sv ***
// Generator protection monitor: qualified alarms with action codes and events
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "alarm_monitor_consts.svh"

module genset_alarm_monitor
   import alarm_monitor_pkg::*;
#(
   parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
   // Clock, reset, enable
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   input  wire logic                   clk_en,
   // Register port
   input  wire logic [`ADDR_W-1:0]     reg_addr,
   input  wire logic [`DATA_W-1:0]     reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [`DATA_W-1:0]     reg_rdata,
   // Engine measurements and state
   input  wire logic [15:0]            battery_voltage,
   input  wire logic                   starter_energized,
   input  wire logic                   at_rated_speed,
   input  wire logic [15:0]            generator_frequency,
   input  wire logic [15:0]            engine_frequency,
   input  wire logic                   speed_bias_at_min,
   input  wire logic                   speed_bias_at_max,
   input  wire logic                   voltage_bias_at_max_volt,
   input  wire logic                   voltage_bias_at_min_volt,
   input  wire logic                   voltage_bias_at_var_limit,
   input  wire logic                   sense_board_fault,
   // Generator measurements and state
   input  wire logic                   synchronizer_enabled,
   input  wire logic [6:0]             negative_sequence_pct,
   input  wire logic [15:0]            phase_a_voltage,
   input  wire logic [15:0]            phase_b_voltage,
   input  wire logic [15:0]            phase_c_voltage,
   input  wire logic                   single_phase,
   input  wire logic                   breaker_closed,
   // Alarm outputs
   output logic      [`NUM_ALARMS-1:0] alarm_active,
   output logic                        event_valid,
   output alarm_id_t                   event_id,
   output action_t                     event_action
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam logic [15:0] BATT_TICKS = 16'(`BATT_DELAY_MS / `TICK_MS);
   localparam logic [15:0] ARM_TICKS  = 16'(`ARM_DELAY_MS / `TICK_MS);
   localparam logic [15:0] BIAS_TICKS = 16'(`BIAS_DELAY_MS / `TICK_MS);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   logic [2:0]               action_reg [`NUM_ALARMS];
   logic [15:0]              setting_reg [`NUM_SETTINGS];
   logic [`NUM_ALARMS-1:0]   alarm_cond;
   logic [15:0]              alarm_limit [`NUM_ALARMS];
   logic [15:0]              timer_reg [`NUM_ALARMS];
   logic [`NUM_ALARMS-1:0]   active_reg;
   logic [`NUM_ALARMS-1:0]   active_prev_reg;
   logic [`NUM_ALARMS-1:0]   pending_reg;
   logic [`NUM_ALARMS-1:0]   pending_next;
   logic [`NUM_ALARMS-1:0]   rise;
   logic [`NUM_ALARMS-1:0]   action_enabled;
   logic [TICK_W-1:0]        tick_cnt_reg;
   logic                     tick;
   logic [15:0]              arm_cnt_reg;
   logic                     armed;
   logic [15:0]              v_max;
   logic [15:0]              v_min;
   logic [15:0]              v_ab_min;
   logic [15:0]              freq_diff;
   logic                     emit;
   logic [3:0]               emit_idx;
   logic [`DATA_W-1:0]       rdata_next;
   logic [`DATA_W-1:0]       rdata_reg;
   logic                     event_valid_reg;
   logic [3:0]               event_id_reg;
   logic [2:0]               event_action_reg;

   function automatic logic [2:0] action_default(input int idx);
      logic [2:0] val;
      case (idx)
         0:       val = `ACT_DEF_BATT_HIGH;
         1:       val = `ACT_DEF_BATT_LOW;
         2:       val = `ACT_DEF_SPD_FREQ;
         3:       val = `ACT_DEF_SPD_BIAS;
         4:       val = `ACT_DEF_VLT_BIAS;
         5:       val = `ACT_DEF_SENSE;
         6:       val = `ACT_DEF_ROTATION;
         7:       val = `ACT_DEF_OV;
         8:       val = `ACT_DEF_OV_PRE;
         9:       val = `ACT_DEF_UV_PRE;
         default: val = `ACT_DEF_UV;
      endcase
      return val;
   endfunction

   function automatic logic [15:0] setting_default(input int idx);
      logic [15:0] val;
      case (idx)
         0:       val = `SET_DEF_BATT_HIGH;
         1:       val = `SET_DEF_BATT_LOW;
         2:       val = `SET_DEF_ROTATION;
         3:       val = `SET_DEF_OV;
         4:       val = `SET_DEF_OV_PRE;
         5:       val = `SET_DEF_UV_PRE;
         6:       val = `SET_DEF_UV;
         7:       val = `SET_DEF_AL_DELAY;
         default: val = `SET_DEF_PRE_DELAY;
      endcase
      return val;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register port

   // Settings change live; timers and alarms keep running
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < `NUM_ALARMS; i++) begin
            action_reg[i] <= action_default(i);
         end
         for (int i = 0; i < `NUM_SETTINGS; i++) begin
            setting_reg[i] <= setting_default(i);
         end
      end else if (clk_en && reg_wr) begin
         for (int i = 0; i < `NUM_ALARMS; i++) begin
            if (reg_addr == `ADDR_ACTION_BASE + 6'(i)) begin
               action_reg[i] <= reg_wdata[2:0];
            end
         end
         for (int i = 0; i < `NUM_SETTINGS; i++) begin
            if (reg_addr == `ADDR_SETTING_BASE + 6'(i)) begin
               setting_reg[i] <= reg_wdata;
            end
         end
      end
   end

   always_comb begin
      rdata_next = '0;
      for (int i = 0; i < `NUM_ALARMS; i++) begin
         if (reg_addr == `ADDR_ACTION_BASE + 6'(i)) begin
            rdata_next = {13'h0000, action_reg[i]};
         end
      end
      for (int i = 0; i < `NUM_SETTINGS; i++) begin
         if (reg_addr == `ADDR_SETTING_BASE + 6'(i)) begin
            rdata_next = setting_reg[i];
         end
      end
      if (reg_addr == `ADDR_ACTIVE) begin
         rdata_next = {5'h00, active_reg};
      end
      if (reg_addr == `ADDR_PENDING) begin
         rdata_next = {5'h00, pending_reg};
      end
      if (reg_addr == `ADDR_ARMED) begin
         rdata_next = {15'h0000, armed};
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= '0;
      end else if (clk_en) begin
         rdata_reg <= reg_rd ? rdata_next : '0;
      end
   end

   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Time base: one tick per tenth of a second

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_reg <= '0;
      end else if (clk_en) begin
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      end
   end

   assign tick = (tick_cnt_reg == TICK_LAST);

   // Rated speed must hold without a break before arming
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         arm_cnt_reg <= '0;
      end else if (clk_en) begin
         if (!at_rated_speed) begin
            arm_cnt_reg <= '0;
         end else if (tick && arm_cnt_reg < ARM_TICKS) begin
            arm_cnt_reg <= arm_cnt_reg + 16'h0001;
         end
      end
   end

   assign armed = at_rated_speed && (arm_cnt_reg >= ARM_TICKS);

   ////////////////////////////////////////////////////////////////////////////
   // Measurement conditioning

   always_comb begin
      v_max = phase_a_voltage;
      if (phase_b_voltage > v_max) begin
         v_max = phase_b_voltage;
      end
      if (phase_c_voltage > v_max) begin
         v_max = phase_c_voltage;
      end
   end

   assign v_ab_min = (phase_b_voltage < phase_a_voltage) ? phase_b_voltage : phase_a_voltage;
   assign v_min = single_phase ? phase_a_voltage :
                  ((phase_c_voltage < v_ab_min) ? phase_c_voltage : v_ab_min);
   assign freq_diff = (generator_frequency > engine_frequency) ?
                      (generator_frequency - engine_frequency) :
                      (engine_frequency - generator_frequency);

   ////////////////////////////////////////////////////////////////////////////
   // Alarm conditions and their qualifying delays

   always_comb begin
      alarm_cond[AL_BATT_HIGH] = !starter_energized &&
                                 (battery_voltage > setting_reg[SET_BATT_HIGH]);
      alarm_cond[AL_BATT_LOW]  = !starter_energized &&
                                 (battery_voltage < setting_reg[SET_BATT_LOW]);
      alarm_cond[AL_SPD_FREQ]  = armed && (freq_diff > `FREQ_TOL);
      alarm_cond[AL_SPD_BIAS]  = speed_bias_at_min || speed_bias_at_max;
      alarm_cond[AL_VLT_BIAS]  = voltage_bias_at_max_volt || voltage_bias_at_min_volt ||
                                 voltage_bias_at_var_limit;
      alarm_cond[AL_SENSE]     = sense_board_fault;
      alarm_cond[AL_ROTATION]  = synchronizer_enabled &&
                                 ({9'h000, negative_sequence_pct} >= setting_reg[SET_ROTATION]);
      alarm_cond[AL_OV]        = v_max > setting_reg[SET_OV];
      alarm_cond[AL_OV_PRE]    = v_max > setting_reg[SET_OV_PRE];
      alarm_cond[AL_UV_PRE]    = breaker_closed && (v_min < setting_reg[SET_UV_PRE]);
      alarm_cond[AL_UV]        = breaker_closed && (v_min < setting_reg[SET_UV]);
   end

   always_comb begin
      alarm_limit[AL_BATT_HIGH] = BATT_TICKS;
      alarm_limit[AL_BATT_LOW]  = BATT_TICKS;
      alarm_limit[AL_SPD_FREQ]  = 16'h0000;
      alarm_limit[AL_SPD_BIAS]  = BIAS_TICKS;
      alarm_limit[AL_VLT_BIAS]  = BIAS_TICKS;
      alarm_limit[AL_SENSE]     = 16'h0000;
      alarm_limit[AL_ROTATION]  = 16'h0000;
      alarm_limit[AL_OV]        = setting_reg[SET_AL_DELAY];
      alarm_limit[AL_OV_PRE]    = setting_reg[SET_PRE_DELAY];
      alarm_limit[AL_UV_PRE]    = setting_reg[SET_PRE_DELAY];
      alarm_limit[AL_UV]        = setting_reg[SET_AL_DELAY];
   end

   genvar g;
   generate
      for (g = 0; g < `NUM_ALARMS; g++) begin : g_alarm
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               timer_reg[g] <= '0;
            end else if (clk_en) begin
               if (!alarm_cond[g]) begin
                  timer_reg[g] <= '0;
               end else if (tick && timer_reg[g] < alarm_limit[g]) begin
                  timer_reg[g] <= timer_reg[g] + 16'h0001;
               end
            end
         end

         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               active_reg[g]      <= 1'b0;
               active_prev_reg[g] <= 1'b0;
            end else if (clk_en) begin
               active_reg[g]      <= alarm_cond[g] && (timer_reg[g] >= alarm_limit[g]);
               active_prev_reg[g] <= active_reg[g];
            end
         end

         // Codes 1, 0 and 7 all keep the alarm silent
         assign action_enabled[g] = (action_reg[g] >= 3'h2) && (action_reg[g] <= 3'h6);
         assign rise[g] = active_reg[g] && !active_prev_reg[g] && action_enabled[g];
      end
   endgenerate

   assign alarm_active = active_reg & action_enabled;

   ////////////////////////////////////////////////////////////////////////////
   // Event emitter: lowest pending identity first

   always_comb begin
      emit     = 1'b0;
      emit_idx = 4'h0;
      for (int i = `NUM_ALARMS - 1; i >= 0; i--) begin
         if (pending_reg[i]) begin
            emit     = 1'b1;
            emit_idx = 4'(i);
         end
      end
   end

   // A new declaration beats the clear of the same bit
   always_comb begin
      pending_next = pending_reg;
      if (emit) begin
         pending_next[emit_idx] = 1'b0;
      end
      pending_next = (pending_next | rise) & action_enabled;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pending_reg <= '0;
      end else if (clk_en) begin
         pending_reg <= pending_next;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         event_valid_reg  <= 1'b0;
         event_id_reg     <= 4'h0;
         event_action_reg <= 3'h1;
      end else if (clk_en) begin
         event_valid_reg <= emit;
         if (emit) begin
            event_id_reg     <= emit_idx;
            event_action_reg <= action_reg[emit_idx];
         end
      end
   end

   assign event_valid  = event_valid_reg && clk_en;
   assign event_id     = alarm_id_t'(event_id_reg);
   assign event_action = action_t'(event_action_reg);

endmodule

// *** sim/genset_alarm_monitor_sva.sv ***
// Concurrent checks on the alarm monitor's ports
`timescale 1ns/100ps
`include "alarm_monitor_consts.svh"

module genset_alarm_monitor_sva
   import alarm_monitor_pkg::*;
#(
   parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
   // Clock, reset, register port
   input wire logic         ref_clk,
   input wire logic         resetn,
   input wire logic         clk_en,
   input wire logic         reg_rd,
   input wire logic [15:0]  reg_rdata,
   // Plant side
   input wire logic         starter_energized,
   input wire logic         at_rated_speed,
   input wire logic [15:0]  generator_frequency,
   input wire logic [15:0]  engine_frequency,
   input wire logic         speed_bias_at_min,
   input wire logic         speed_bias_at_max,
   input wire logic         voltage_bias_at_max_volt,
   input wire logic         voltage_bias_at_min_volt,
   input wire logic         voltage_bias_at_var_limit,
   input wire logic         sense_board_fault,
   input wire logic         synchronizer_enabled,
   input wire logic         breaker_closed,
   // Alarm side
   input wire logic [10:0]  alarm_active,
   input wire logic         event_valid,
   input action_t           event_action
);

   int   nostart_cnt;
   int   rated_cnt;
   int   spd_cnt;
   int   vlt_cnt;
   wire  spd_sat   = speed_bias_at_min | speed_bias_at_max;
   wire  vlt_sat   = voltage_bias_at_max_volt | voltage_bias_at_min_volt | voltage_bias_at_var_limit;
   wire  [15:0] freq_diff = (generator_frequency > engine_frequency) ? generator_frequency - engine_frequency
                  : engine_frequency - generator_frequency;

   ////////////////////////////////////////////////////////////////////////////////
   // Consecutive enabled cycles of the starter-off, rated-speed, speed-bias and voltage-bias conditions
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         nostart_cnt <= 0;
         rated_cnt   <= 0;
         spd_cnt     <= 0;
         vlt_cnt     <= 0;
      end else if (clk_en) begin
         nostart_cnt <= starter_energized ? 0 : nostart_cnt + 1;
         rated_cnt   <= at_rated_speed ? rated_cnt + 1 : 0;
         spd_cnt     <= spd_sat ? spd_cnt + 1 : 0;
         vlt_cnt     <= vlt_sat ? vlt_cnt + 1 : 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_read_taken;
      $past(reg_rd) && $past(clk_en);
   endsequence

   a_batt_starter_block: assert property ((|alarm_active[1:0]) && $past(clk_en) |-> !$past(starter_energized))
      else $error("battery alarm with starter on");
   a_batt_high_delay: assert property (alarm_active[0] |-> nostart_cnt >= 9 * TICK_CYCLES)
      else $error("battery high declared too early");
   a_batt_low_delay: assert property (alarm_active[1] |-> nostart_cnt >= 9 * TICK_CYCLES)
      else $error("battery low declared too early");
   a_mismatch_armed: assert property (alarm_active[2] |-> rated_cnt >= 49 * TICK_CYCLES)
      else $error("mismatch before arming");
   a_mismatch_diff: assert property (alarm_active[2] && $past(clk_en) |-> $past(freq_diff) > 16'h0064)
      else $error("mismatch within tolerance");
   a_speed_bias_delay: assert property (alarm_active[3] |-> spd_cnt >= 99 * TICK_CYCLES)
      else $error("speed bias alarm too early");
   a_volt_bias_delay: assert property (alarm_active[4] |-> vlt_cnt >= 99 * TICK_CYCLES)
      else $error("voltage bias alarm too early");
   a_sense_fault_cause: assert property (alarm_active[5] && $past(clk_en) |-> $past(sense_board_fault))
      else $error("sense alarm without fault");
   a_rotation_sync_only: assert property (alarm_active[6] && $past(clk_en) |-> $past(synchronizer_enabled))
      else $error("rotation alarm with synchronizer off");
   a_uv_breaker_only: assert property ((|alarm_active[10:9]) && $past(clk_en) |-> $past(breaker_closed))
      else $error("under voltage with breaker open");
   a_event_action_valid: assert property (event_valid |-> event_action inside {[3'h2:3'h6]})
      else $error("event with disabled action");
   a_read_data_window: assert property (reg_rdata != 16'h0000 |-> s_read_taken)
      else $error("read data outside read window");

endmodule

// *** sim/plant.sv ***
// Steady engine and generator plant model, steered by the bench between edges
`timescale 1ns/100ps

module plant (
   // Engine side
   output logic [15:0] battery_voltage           = 16'h00F0,
   output logic        starter_energized         = 1'b0,
   output logic        at_rated_speed            = 1'b0,
   output logic [15:0] generator_frequency       = 16'h1770,
   output logic [15:0] engine_frequency          = 16'h1770,
   output logic        speed_bias_at_min         = 1'b0,
   output logic        speed_bias_at_max         = 1'b0,
   output logic        voltage_bias_at_max_volt  = 1'b0,
   output logic        voltage_bias_at_min_volt  = 1'b0,
   output logic        voltage_bias_at_var_limit = 1'b0,
   output logic        sense_board_fault         = 1'b0,
   // Generator side
   output logic        synchronizer_enabled      = 1'b0,
   output logic [6:0]  negative_sequence_pct     = 7'h00,
   output logic [15:0] phase_a_voltage           = 16'h01E0,
   output logic [15:0] phase_b_voltage           = 16'h01E0,
   output logic [15:0] phase_c_voltage           = 16'h01E0,
   output logic        single_phase              = 1'b0,
   output logic        breaker_closed            = 1'b0
);
endmodule

// *** sim/test_genset_alarm_monitor.sv ***
// Self-checking bench for the generator alarm monitor
`timescale 1ns/100ps

module test_genset_alarm_monitor;
   import alarm_monitor_pkg::*;
   localparam int TICK = 10;
   localparam logic [2:0]  ACT_DEF [11] = '{3'h4, 3'h4, 3'h6, 3'h2, 3'h2, 3'h4, 3'h6, 3'h6, 3'h1, 3'h1, 3'h5};
   localparam logic [15:0] SET_DEF [9]  = '{16'h0118, 16'h00B4, 16'h0032, 16'h0258, 16'h0226, 16'h0190,
                                            16'h012C, 16'h0064, 16'h0032};
   logic             ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [5:0]       reg_addr = 6'h00;
   logic [15:0]      reg_wdata = 16'h0000;
   wire logic [15:0] reg_rdata, battery_voltage, generator_frequency, engine_frequency;
   wire logic [15:0] phase_a_voltage, phase_b_voltage, phase_c_voltage;
   wire logic [6:0]  negative_sequence_pct;
   wire logic        starter_energized, at_rated_speed, speed_bias_at_min, speed_bias_at_max, sense_board_fault;
   wire logic        voltage_bias_at_max_volt, voltage_bias_at_min_volt, voltage_bias_at_var_limit;
   wire logic        synchronizer_enabled, single_phase, breaker_closed, event_valid;
   wire logic [10:0] alarm_active;
   alarm_id_t        event_id;
   action_t          event_action;
   int               miscompares = 0;
   int               checks_done = 0;

   plant plant_inst (.*);
   genset_alarm_monitor #(.TICK_CYCLES(TICK)) genset_alarm_monitor_inst (.*);

   initial forever #25 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   task rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Alarm bit low for lo cycles, up by hi
   task rise_in(input int idx, input int lo, input int hi);
      int n;
      n = 0;
      while (alarm_active[idx] !== 1'b1 && n < hi) begin
         cyc(1);
         n++;
      end
      check(16'(n >= lo), 16'h0001);
      check(16'(alarm_active[idx]), 16'h0001);
   endtask

   task expect_event(input alarm_id_t id, input action_t act);
      int n;
      n = 0;
      while (event_valid !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      check(16'(event_valid), 16'h0001);
      check(16'(event_id), 16'(id));
      check(16'(event_action), 16'(act));
      cyc(1);
   endtask

   task set_sat(input logic [4:0] s);
      {plant_inst.voltage_bias_at_var_limit, plant_inst.voltage_bias_at_min_volt,
       plant_inst.voltage_bias_at_max_volt, plant_inst.speed_bias_at_max,
       plant_inst.speed_bias_at_min} <= s;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task t_defaults;
      logic [15:0] d;
      for (int i = 0; i < 11; i++) begin
         rd(6'(i), d);
         check(d, 16'(ACT_DEF[i]));
      end
      for (int i = 0; i < 9; i++) begin
         rd(6'h10 + 6'(i), d);
         check(d, SET_DEF[i]);
      end
      rd(6'h3F, d);
      check(d, 16'h0000);
      $display("defaults test done");
   endtask

   task t_sense;
      for (int a = 2; a <= 6; a++) begin
         wr(6'h05, 16'(a));
         plant_inst.sense_board_fault <= 1'b1;
         rise_in(5, 1, 2);
         expect_event(AL_SENSE, action_t'(a));
         plant_inst.sense_board_fault <= 1'b0;
         cyc(2);
      end
      wr(6'h05, 16'h0001);
      plant_inst.sense_board_fault <= 1'b1;
      repeat (5) begin
         cyc(1);
         check(16'(event_valid), 16'h0000);
      end
      check(16'(alarm_active[5]), 16'h0000);
      plant_inst.sense_board_fault <= 1'b0;
      wr(6'h05, 16'h0004);
      $display("sense test done");
   endtask

   task t_battery;
      plant_inst.starter_energized <= 1'b1;
      plant_inst.battery_voltage   <= 16'h0119;
      cyc(20 * TICK);
      check(16'(alarm_active[0]), 16'h0000);
      plant_inst.starter_energized <= 1'b0;
      cyc(8 * TICK);
      plant_inst.battery_voltage <= 16'h0118;
      cyc(1);
      plant_inst.battery_voltage <= 16'h0119;
      rise_in(0, 9 * TICK, 12 * TICK);
      expect_event(AL_BATT_HIGH, ACT_AUDIBLE);
      plant_inst.battery_voltage <= 16'h00B3;
      rise_in(1, 9 * TICK, 12 * TICK);
      plant_inst.battery_voltage <= 16'h00F0;
      $display("battery test done");
   endtask

   task t_mismatch;
      logic [15:0] d;
      plant_inst.engine_frequency <= 16'h17D5;
      plant_inst.at_rated_speed   <= 1'b1;
      rise_in(2, 48 * TICK, 52 * TICK);
      expect_event(AL_SPD_FREQ, ACT_HARD);
      rd(6'h22, d);
      check(d, 16'h0001);
      plant_inst.engine_frequency <= 16'h17D4;
      cyc(3);
      check(16'(alarm_active[2]), 16'h0000);
      plant_inst.at_rated_speed   <= 1'b0;
      plant_inst.engine_frequency <= 16'h1770;
      $display("mismatch test done");
   endtask

   task t_bias;
      for (int s = 0; s < 5; s++) begin
         set_sat(5'(1 << s));
         rise_in(s < 2 ? 3 : 4, 98 * TICK, 102 * TICK);
         set_sat(5'h00);
         cyc(2);
      end
      $display("bias test done");
   endtask

   task t_rotation;
      plant_inst.negative_sequence_pct <= 7'h32;
      cyc(10);
      check(16'(alarm_active[6]), 16'h0000);
      plant_inst.synchronizer_enabled <= 1'b1;
      rise_in(6, 1, 3);
      plant_inst.negative_sequence_pct <= 7'h31;
      cyc(2);
      check(16'(alarm_active[6]), 16'h0000);
      wr(6'h12, 16'h0064);
      plant_inst.negative_sequence_pct <= 7'h64;
      rise_in(6, 1, 3);
      plant_inst.synchronizer_enabled  <= 1'b0;
      plant_inst.negative_sequence_pct <= 7'h00;
      $display("rotation test done");
   endtask

   task t_voltage;
      wr(6'h17, 16'h0003);
      wr(6'h18, 16'h0002);
      wr(6'h08, 16'h0002);
      wr(6'h09, 16'h0002);
      plant_inst.phase_b_voltage <= 16'h0230;
      rise_in(8, TICK, 4 * TICK);
      cyc(5 * TICK);
      check(16'(alarm_active[7]), 16'h0000);
      plant_inst.phase_b_voltage <= 16'h0259;
      rise_in(7, 2 * TICK, 5 * TICK);
      plant_inst.phase_b_voltage <= 16'h01E0;
      plant_inst.phase_c_voltage <= 16'h0064;
      cyc(6 * TICK);
      check(16'(alarm_active[10:9]), 16'h0000);
      plant_inst.single_phase   <= 1'b1;
      plant_inst.breaker_closed <= 1'b1;
      cyc(6 * TICK);
      check(16'(alarm_active[10]), 16'h0000);
      plant_inst.single_phase <= 1'b0;
      rise_in(10, 2 * TICK, 5 * TICK);
      check(16'(alarm_active[9]), 16'h0001);
      plant_inst.breaker_closed  <= 1'b0;
      plant_inst.phase_c_voltage <= 16'h01E0;
      $display("voltage test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      cyc(5);
      check(16'(alarm_active), 16'h0000);
      check(16'(event_action), 16'h0001);
      resetn <= 1'b1;
      t_defaults();
      t_sense();
      t_battery();
      t_mismatch();
      t_bias();
      t_rotation();
      t_voltage();
      finish_test();
   end

   // Whole run is near 6400 cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      finish_test();
   end

endmodule

bind genset_alarm_monitor genset_alarm_monitor_sva #(.TICK_CYCLES(TICK_CYCLES)) genset_alarm_monitor_sva_inst (.*);
